// File: hdl/eiec_defines.vh
// constants for the edge interrupt and exception controller
`ifndef EIEC_DEFINES_VH
`define EIEC_DEFINES_VH

// register byte offsets on the avalon slave
`define EIEC_OFS_WAKE_EDGE     6'h00
`define EIEC_OFS_EXT_EDGE      6'h04
`define EIEC_OFS_EVT_EDGE      6'h08
`define EIEC_OFS_ENABLE_A      6'h0c
`define EIEC_OFS_REQ_A         6'h10
`define EIEC_OFS_WAKE_REQ      6'h14
`define EIEC_OFS_PERIPH_EN     6'h18
`define EIEC_OFS_PERIPH_REQ    6'h1c
`define EIEC_OFS_PORT_WAKE     6'h20
`define EIEC_OFS_PORT_EXT      6'h24
`define EIEC_OFS_STATUS        6'h28

// bit positions in the enable and request registers
`define EIEC_BIT_EXT_A         0
`define EIEC_BIT_EXT_B         1
`define EIEC_BIT_EVT           2
`define EIEC_BIT_WAKE          3

// reset values
`define EIEC_RST_BYTE          8'h00
`define EIEC_RST_CCR           8'h80
`define EIEC_CCR_I_BIT         7

// exception sequence lengths in states
`define EIEC_STACK_STATES      4'h4
`define EIEC_VEC_STATES        4'h2
`define EIEC_FETCH_STATES      4'h4
`define EIEC_INTP_STATES       4'h4

// vector table word indexes, byte address is twice the index
`define EIEC_VEC_RESET         5'h00
`define EIEC_VEC_EXT_A         5'h04
`define EIEC_VEC_EXT_B         5'h05
`define EIEC_VEC_EVT           5'h06
`define EIEC_VEC_WAKE          5'h07
`define EIEC_VEC_PERIPH0       5'h08

`endif

// File: hdl/eiec_ctrl.v
// interrupt, edge detection and exception sequencer with avalon register slave
//
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "eiec_defines.vh"

// Function
// - each wakeup edge select bit: 0 falling edge, 1 rising edge on its pin
// - while reset is low all state and registers are held initialised
// - after reset: mask bit set, vector at 0000 loaded into pc
// - eight wakeup pins share one vector, each edge detected separately
// - selected wakeup edge sets its flag; one shared enable masks all eight
// - two external pins have separate vectors and own edge select bits
// - selected external edge sets its flag; each pin has its own enable
// - event pin edge from two-bit field; flag set only while enabled
// - peripherals have flag and enable; enable 0 masks the request
// - request reaches arbitration only while its enable is 1
// - only highest priority request presented, others stay pending
// - accepted only while mask bit is 0, else pending
// - accept after instruction ends; push pc and ccr, pc is return address
// - mask bit set after stacking; restore of ccr on return
// - vector of accepted interrupt loaded into pc, execution starts there
// - clear colliding with new request still runs that exception
// - response: 4 stacking, 2 vector, 4 fetch, 4 internal states
// - requests disabled after reset until first instruction has run
// - word accesses and stack use an even address
// - flags never clear on accept; writing 0 clears, 1 has no effect
module eiec_ctrl #(
    parameter NP = 4
) (
    input  wire        sys_clk,
    input  wire        rst_b,
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire [7:0]  wakeup_pin_n,
    input  wire        ext_int_pin_a,
    input  wire        ext_int_pin_b,
    input  wire        event_counter_int_pin,
    input  wire [NP-1:0] periph_evt,
    input  wire        cpu_insn_end,
    input  wire [15:0] cpu_pc,
    input  wire [15:0] cpu_sp,
    input  wire        ccr_wr,
    input  wire [7:0]  ccr_wdata,
    output reg  [7:0]  condition_code_reg,
    output reg         irq_req,
    output reg  [15:0] irq_vec,
    output reg         exc_busy,
    output reg  [15:0] mem_addr,
    output reg         mem_rd,
    output reg         mem_wr,
    output reg  [15:0] mem_wdata,
    input  wire [15:0] mem_rdata,
    output reg         pc_load,
    output reg  [15:0] pc_value,
    output reg         sp_load,
    output reg  [15:0] sp_value
);

    localparam NPIN = 11;
    localparam NREQ = 4 + NP;

    // sequencer states
    localparam [2:0] ST_RVEC  = 3'h0;
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_STACK = 3'h2;
    localparam [2:0] ST_VEC   = 3'h3;
    localparam [2:0] ST_FETCH = 3'h4;
    localparam [2:0] ST_INTP  = 3'h5;

    // software registers
    reg  [7:0]      wakeup_edge_select_r;
    reg  [1:0]      ext_int_edge_select_r;
    reg  [1:0]      event_edge_select_reg_r;
    reg  [3:0]      int_enable_reg_a_r;
    reg  [2:0]      int_request_flags_a_r;
    reg  [7:0]      wakeup_request_flags_r;
    reg  [NP-1:0]   periph_en_r;
    reg  [NP-1:0]   periph_req_r;
    reg  [7:0]      port_mode_wakeup_r;
    reg  [1:0]      port_mode_ext_r;

    // pin synchronisers and edge history
    reg  [NPIN-1:0] sync1_r;
    reg  [NPIN-1:0] sync2_r;
    reg  [NPIN-1:0] sync3_r;
    wire [NPIN-1:0] pins;
    wire [NPIN-1:0] rise;
    wire [NPIN-1:0] fall;

    // sequencer state
    reg  [2:0]      state_r;
    reg  [3:0]      cnt_r;
    reg  [4:0]      vec_idx_r;
    reg             first_done_r;
    reg  [15:0]     sp_work_r;

    // bus decode
    wire            bus_take;
    wire            wr_go;
    reg  [31:0]     rd_nxt;

    // arbitration
    wire [NREQ-1:0] req_vec;
    reg             any_req;
    reg  [4:0]      win_idx;
    integer         k;

    // event set lines
    wire [7:0]      wake_set;
    wire            ext_a_set;
    wire            ext_b_set;
    reg             evt_edge;
    wire [2:0]      req_a_set;

    // pin order: wakeup 7..0, ext a, ext b, event counter
    assign pins = {event_counter_int_pin, ext_int_pin_b, ext_int_pin_a, wakeup_pin_n};

    // two-stage synchroniser, third stage only for edge history
    // history resets high: active-low pins idle high, so no false edge
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= {NPIN{1'b1}};
            sync2_r <= {NPIN{1'b1}};
            sync3_r <= {NPIN{1'b1}};
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // per-pin edge detectors on the synchronised levels
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_edge
            assign rise[g] = sync2_r[g] & ~sync3_r[g];
            assign fall[g] = ~sync2_r[g] & sync3_r[g];
        end
    endgenerate

    // wakeup edges: each pin on its own select bit, gated by port mode
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_wake
            assign wake_set[g] = port_mode_wakeup_r[g] &
                (wakeup_edge_select_r[g] ? rise[g] : fall[g]);
        end
    endgenerate

    // external pins each on own edge bit; event pin on two-bit field
    assign ext_a_set = port_mode_ext_r[0] &
        (ext_int_edge_select_r[0] ? rise[8] : fall[8]);
    assign ext_b_set = port_mode_ext_r[1] &
        (ext_int_edge_select_r[1] ? rise[9] : fall[9]);

    always @* begin
        case (event_edge_select_reg_r)
            2'b00:   evt_edge = fall[10];
            2'b01:   evt_edge = rise[10];
            default: evt_edge = rise[10] | fall[10];
        endcase
    end

    assign req_a_set = {evt_edge & int_enable_reg_a_r[`EIEC_BIT_EVT], ext_b_set, ext_a_set};

    // avalon handshake: one wait cycle, then the access completes
    assign bus_take = (avs_read | avs_write) & avs_waitrequest;
    assign wr_go    = avs_write & ~avs_waitrequest;

    // read mux, unmapped addresses read zero
    always @* begin
        rd_nxt = 32'h0000_0000;
        case (avs_address)
            `EIEC_OFS_WAKE_EDGE:  rd_nxt[7:0] = wakeup_edge_select_r;
            `EIEC_OFS_EXT_EDGE:   rd_nxt[1:0] = ext_int_edge_select_r;
            `EIEC_OFS_EVT_EDGE:   rd_nxt[1:0] = event_edge_select_reg_r;
            `EIEC_OFS_ENABLE_A:   rd_nxt[3:0] = int_enable_reg_a_r;
            `EIEC_OFS_REQ_A:      rd_nxt[2:0] = int_request_flags_a_r;
            `EIEC_OFS_WAKE_REQ:   rd_nxt[7:0] = wakeup_request_flags_r;
            `EIEC_OFS_PERIPH_EN:  rd_nxt[NP-1:0] = periph_en_r;
            `EIEC_OFS_PERIPH_REQ: rd_nxt[NP-1:0] = periph_req_r;
            `EIEC_OFS_PORT_WAKE:  rd_nxt[7:0] = port_mode_wakeup_r;
            `EIEC_OFS_PORT_EXT:   rd_nxt[1:0] = port_mode_ext_r;
            `EIEC_OFS_STATUS:     rd_nxt[10:0] = {first_done_r, vec_idx_r, exc_busy,
                                                  state_r, condition_code_reg[`EIEC_CCR_I_BIT]};
            default:              rd_nxt = 32'h0000_0000;
        endcase
    end

    // bus slave and plain control registers
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest         <= 1'b1;
            avs_readdata            <= 32'h0000_0000;
            wakeup_edge_select_r    <= `EIEC_RST_BYTE;
            ext_int_edge_select_r   <= 2'h0;
            event_edge_select_reg_r <= 2'h0;
            int_enable_reg_a_r      <= 4'h0;
            periph_en_r             <= {NP{1'b0}};
            port_mode_wakeup_r      <= `EIEC_RST_BYTE;
            port_mode_ext_r         <= 2'h0;
        end else begin
            avs_waitrequest <= ~bus_take;
            if (avs_read & avs_waitrequest)
                avs_readdata <= rd_nxt;
            if (wr_go) begin
                case (avs_address)
                    `EIEC_OFS_WAKE_EDGE: wakeup_edge_select_r <= avs_writedata[7:0];
                    `EIEC_OFS_EXT_EDGE:  ext_int_edge_select_r <= avs_writedata[1:0];
                    `EIEC_OFS_EVT_EDGE:  event_edge_select_reg_r <= avs_writedata[1:0];
                    `EIEC_OFS_ENABLE_A:  int_enable_reg_a_r <= avs_writedata[3:0];
                    `EIEC_OFS_PERIPH_EN: periph_en_r <= avs_writedata[NP-1:0];
                    `EIEC_OFS_PORT_WAKE: port_mode_wakeup_r <= avs_writedata[7:0];
                    `EIEC_OFS_PORT_EXT:  port_mode_ext_r <= avs_writedata[1:0];
                    default: ;
                endcase
            end
        end
    end

    // request flags: write 0 clears, write 1 keeps, a new event wins over a clear
    // a flag set while software clears another one is never lost
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            int_request_flags_a_r  <= 3'h0;
            wakeup_request_flags_r <= `EIEC_RST_BYTE;
            periph_req_r           <= {NP{1'b0}};
        end else begin
            int_request_flags_a_r <= req_a_set | (int_request_flags_a_r &
                ((wr_go && avs_address == `EIEC_OFS_REQ_A) ?
                 avs_writedata[2:0] : 3'h7));
            wakeup_request_flags_r <= wake_set | (wakeup_request_flags_r &
                ((wr_go && avs_address == `EIEC_OFS_WAKE_REQ) ?
                 avs_writedata[7:0] : 8'hff));
            periph_req_r <= periph_evt | (periph_req_r &
                ((wr_go && avs_address == `EIEC_OFS_PERIPH_REQ) ?
                 avs_writedata[NP-1:0] : {NP{1'b1}}));
        end
    end

    // enabled requests only, in fixed priority order, lowest index first
    assign req_vec = {periph_req_r & periph_en_r,
                      (|wakeup_request_flags_r) & int_enable_reg_a_r[`EIEC_BIT_WAKE],
                      int_request_flags_a_r & int_enable_reg_a_r[2:0]};

    // priority pick of the winning request
    always @* begin
        any_req = 1'b0;
        win_idx = 5'h00;
        for (k = NREQ - 1; k >= 0; k = k - 1) begin
            if (req_vec[k]) begin
                any_req = 1'b1;
                win_idx = k[4:0];
            end
        end
    end

    // exception sequencer: reset vector, stacking, vector fetch, fetch, internal
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r            <= ST_RVEC;
            cnt_r              <= 4'h0;
            vec_idx_r          <= `EIEC_VEC_RESET;
            first_done_r       <= 1'b0;
            sp_work_r          <= 16'h0000;
            condition_code_reg <= `EIEC_RST_CCR;
            irq_req            <= 1'b0;
            irq_vec            <= 16'h0000;
            exc_busy           <= 1'b1;
            mem_addr           <= 16'h0000;
            mem_rd             <= 1'b0;
            mem_wr             <= 1'b0;
            mem_wdata          <= 16'h0000;
            pc_load            <= 1'b0;
            pc_value           <= 16'h0000;
            sp_load            <= 1'b0;
            sp_value           <= 16'h0000;
        end else begin
            mem_rd  <= 1'b0;
            mem_wr  <= 1'b0;
            pc_load <= 1'b0;
            sp_load <= 1'b0;
            cnt_r   <= cnt_r + 4'h1;
            // presented request, held off until the first instruction ran
            irq_req <= any_req & first_done_r;
            // vector byte address of the current winner
            irq_vec <= {10'h000, win_idx + `EIEC_VEC_PERIPH0 - 5'h04, 1'b0};
            if (ccr_wr && state_r == ST_IDLE)
                condition_code_reg <= ccr_wdata;
            case (state_r)
                ST_RVEC: begin
                    if (cnt_r == 4'h0) begin
                        mem_addr <= {10'h000, `EIEC_VEC_RESET, 1'b0};
                        mem_rd   <= 1'b1;
                    end else begin
                        pc_value <= {mem_rdata[15:1], 1'b0};
                        pc_load  <= 1'b1;
                        exc_busy <= 1'b0;
                        state_r  <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    // insn_end pulses during a sequence never land here
                    cnt_r <= 4'h0;
                    if (cpu_insn_end) begin
                        first_done_r <= 1'b1;
                        if (irq_req && !condition_code_reg[`EIEC_CCR_I_BIT]) begin
                            vec_idx_r <= (win_idx < 5'h04) ? win_idx + `EIEC_VEC_EXT_A :
                                         win_idx + `EIEC_VEC_PERIPH0 - 5'h04;
                            sp_work_r <= {cpu_sp[15:1], 1'b0};
                            exc_busy  <= 1'b1;
                            state_r   <= ST_STACK;
                        end
                    end
                end
                ST_STACK: begin
                    // pc word at sp-2 first, ccr word at sp-4 two states later
                    if (cnt_r == 4'h0) begin
                        mem_addr  <= sp_work_r - 16'h0002;
                        mem_wdata <= {cpu_pc[15:1], 1'b0};
                        mem_wr    <= 1'b1;
                    end else if (cnt_r == 4'h2) begin
                        mem_addr  <= sp_work_r - 16'h0004;
                        mem_wdata <= {condition_code_reg, condition_code_reg};
                        mem_wr    <= 1'b1;
                    end else if (cnt_r == `EIEC_STACK_STATES - 4'h1) begin
                        sp_value <= sp_work_r - 16'h0004;
                        sp_load  <= 1'b1;
                        condition_code_reg[`EIEC_CCR_I_BIT] <= 1'b1;
                        cnt_r    <= 4'h0;
                        state_r  <= ST_VEC;
                    end
                end
                ST_VEC: begin
                    if (cnt_r == 4'h0) begin
                        mem_addr <= {10'h000, vec_idx_r, 1'b0};
                        mem_rd   <= 1'b1;
                    end else begin
                        pc_value <= {mem_rdata[15:1], 1'b0};
                        pc_load  <= 1'b1;
                        cnt_r    <= 4'h0;
                        state_r  <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    // cpu fetches the handler's first word, we only count
                    if (cnt_r == `EIEC_FETCH_STATES - 4'h1) begin
                        cnt_r   <= 4'h0;
                        state_r <= ST_INTP;
                    end
                end
                ST_INTP: begin
                    // internal states, then the cpu runs the handler
                    if (cnt_r == `EIEC_INTP_STATES - 4'h1) begin
                        exc_busy <= 1'b0;
                        state_r  <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // eiec_ctrl
`default_nettype wire

// File: dv/eiec_ctrl_props.sv
// concurrent checks on the controller ports
`timescale 1ns/1ps
`default_nettype none
module eiec_ctrl_props (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic        cpu_insn_end,
    input wire logic [15:0] cpu_pc,
    input wire logic [15:0] cpu_sp,
    input wire logic [7:0]  condition_code_reg,
    input wire logic        irq_req,
    input wire logic [15:0] irq_vec,
    input wire logic        exc_busy,
    input wire logic [15:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [15:0] mem_wdata,
    input wire logic        pc_load,
    input wire logic [15:0] pc_value,
    input wire logic        sp_load,
    input wire logic [15:0] sp_value
);
    logic first_r;
    wire  acc = cpu_insn_end && irq_req && !condition_code_reg[7] && !exc_busy;
    // remembers that the first instruction after reset has completed
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            first_r <= 1'h0;
        else if (cpu_insn_end)
            first_r <= 1'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_push_pc: assert property (acc |-> ##2 exc_busy && mem_wr
        && mem_addr == $past(cpu_sp, 2) - 16'h2 && mem_wdata == $past(cpu_pc))
        else $error("pc push wrong");
    a_push_ccr: assert property (acc |-> ##4 mem_wr
        && mem_addr == $past(cpu_sp, 4) - 16'h4
        && mem_wdata == {2{$past(condition_code_reg, 4)}}) else $error("ccr push wrong");
    a_mask_set: assert property (acc |-> ##4 !condition_code_reg[7] ##1 sp_load
        && sp_value == $past(cpu_sp, 5) - 16'h4 && condition_code_reg[7])
        else $error("mask not set after stacking");
    a_vector_read: assert property (acc |-> ##6 mem_rd && mem_addr == $past(irq_vec, 6))
        else $error("vector fetch wrong");
    a_resp_len: assert property (acc |-> ##14 exc_busy ##1 !exc_busy)
        else $error("response length wrong");
    a_masked_hold: assert property (condition_code_reg[7] && !exc_busy |=> !exc_busy)
        else $error("accepted while masked");
    a_first_insn: assert property (!first_r |-> !irq_req)
        else $error("request before first instruction");
    a_reset_fetch: assert property ($rose(rst_b) |-> ##[1:2] mem_rd && mem_addr == 16'h0
        && condition_code_reg == 8'h80) else $error("reset vector fetch wrong");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer wrong");
    a_pc_even: assert property (pc_load |-> pc_value[0] == 1'h0)
        else $error("odd pc loaded");
endmodule // eiec_ctrl_props
`default_nettype wire

// File: dv/eiec_cpu_model.sv
// behavioural cpu core and word memory facing the controller
`timescale 1ns/1ps
`default_nettype none
module eiec_cpu_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        run,
    input  wire logic        exc_busy,
    input  wire logic        pc_load,
    input  wire logic [15:0] pc_value,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [15:0] mem_wdata,
    output logic      [15:0] mem_rdata,
    output logic             cpu_insn_end,
    output logic      [15:0] cpu_pc,
    output logic      [15:0] cpu_sp,
    output logic             ccr_wr,
    output logic      [7:0]  ccr_wdata
);
    logic [15:0] ram [0:255];
    logic [1:0]  cnt_r;
    logic [15:0] noise_r;
    // vector words carry a set low bit so that forcing to even shows
    initial begin
        for (int k = 0; k < 16; k++)
            ram[k] = 16'h4001 + 16'(k << 8);
        noise_r   = 16'h0;
        ccr_wr    = 1'h0;
        ccr_wdata = 8'h0;
        cpu_sp    = 16'h0100;
    end
    // one instruction ends every four cycles while running and not halted
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r        <= 2'h0;
            cpu_insn_end <= 1'h0;
            cpu_pc       <= 16'h0;
        end else begin
            cnt_r        <= cnt_r + 2'h1;
            cpu_insn_end <= run && !exc_busy && cnt_r == 2'h3;
            if (pc_load)
                cpu_pc <= pc_value;
            else if (cpu_insn_end)
                cpu_pc <= cpu_pc + 16'h2;
        end
    end
    // read data valid while the strobe stands, toggling otherwise
    always @(posedge sys_clk) begin
        if (mem_wr)
            ram[mem_addr[8:1]] <= mem_wdata;
        noise_r <= ~noise_r;
    end
    assign mem_rdata = mem_rd ? ram[mem_addr[8:1]] : noise_r;
    // ccr write, also used as the return-from-handler restore
    task automatic set_ccr(input logic [7:0] v);
        @(posedge sys_clk);
        ccr_wdata <= v;
        ccr_wr    <= 1'h1;
        @(posedge sys_clk);
        ccr_wr    <= 1'h0;
    endtask
endmodule // eiec_cpu_model
`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the edge interrupt and exception controller
`timescale 1ns/1ps
`default_nettype none
`include "eiec_defines.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
    logic        sys_clk = 1'h0;
    logic        rst_b = 1'h0;
    logic [5:0]  avs_address = 6'h0;
    logic        avs_read = 1'h0;
    logic        avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [7:0]  wakeup_pin_n = 8'hff;
    logic        ext_int_pin_a = 1'h0;
    logic        ext_int_pin_b = 1'h0;
    logic        event_counter_int_pin = 1'h0;
    logic [3:0]  periph_evt = 4'h0;
    logic        run = 1'h0;
    logic        avs_waitrequest, cpu_insn_end, ccr_wr, irq_req, exc_busy;
    logic        mem_rd, mem_wr, pc_load, sp_load;
    logic [15:0] cpu_pc, cpu_sp, irq_vec, mem_addr, mem_wdata, mem_rdata, pc_value, sp_value;
    logic [7:0]  ccr_wdata, condition_code_reg;
    logic [31:0] avs_readdata, rd;
    logic [15:0] pcv;
    int          n_errors = 0;
    int          num_checks = 0;
    eiec_ctrl dut (.sys_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .wakeup_pin_n, .ext_int_pin_a, .ext_int_pin_b,
        .event_counter_int_pin, .periph_evt, .cpu_insn_end, .cpu_pc, .cpu_sp, .ccr_wr,
        .ccr_wdata, .condition_code_reg, .irq_req, .irq_vec, .exc_busy, .mem_addr, .mem_rd,
        .mem_wr, .mem_wdata, .mem_rdata, .pc_load, .pc_value, .sp_load, .sp_value);
    eiec_cpu_model cpu (.sys_clk, .rst_b, .run, .exc_busy, .pc_load, .pc_value, .mem_addr,
        .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .cpu_insn_end, .cpu_pc, .cpu_sp, .ccr_wr,
        .ccr_wdata);
    // 25 MHz system clock
    always #20 sys_clk = ~sys_clk;
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin @(posedge sys_clk); n++; end while (avs_waitrequest !== 1'h0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read  <= 1'h0;
        `CHK("bus answer", 1'h0, avs_waitrequest)
    endtask
    // waits for the handler pc load, then for the sequence to end
    task automatic take_exc();
        int n = 0;
        while (pc_load !== 1'h1 && n < 100) begin @(posedge sys_clk); n++; end
        pcv = pc_value;
        `CHK("pc load", 1'h1, pc_load)
        while (exc_busy !== 1'h0 && n < 200) begin @(posedge sys_clk); n++; end
        `CHK("sequence end", 1'h0, exc_busy)
    endtask
    task automatic t_reset();
        take_exc();
        `CHK("reset pc", 16'h4000, pcv)
        `CHK("reset ccr", 8'h80, condition_code_reg)
        bus(0, `EIEC_OFS_WAKE_EDGE, 0);
        `CHK("wake edge reset", 32'h0, rd)
        bus(1, 6'h3c, 32'hff);
        bus(0, 6'h3c, 0);
        `CHK("unmapped read", 32'h0, rd)
    endtask
    task automatic t_wake();
        bus(1, `EIEC_OFS_PORT_WAKE, 32'hff);
        bus(1, `EIEC_OFS_WAKE_EDGE, 32'h0f);
        bus(0, `EIEC_OFS_WAKE_EDGE, 0);
        `CHK("wake edge sel", 32'h0f, rd)
        @(posedge sys_clk) wakeup_pin_n <= 8'h00;
        idle(8);
        bus(0, `EIEC_OFS_WAKE_REQ, 0);
        `CHK("wake falling", 32'hf0, rd)
        @(posedge sys_clk) wakeup_pin_n <= 8'hff;
        idle(8);
        bus(0, `EIEC_OFS_WAKE_REQ, 0);
        `CHK("wake rising", 32'hff, rd)
        bus(1, `EIEC_OFS_WAKE_REQ, 32'hf0);
        bus(0, `EIEC_OFS_WAKE_REQ, 0);
        `CHK("wake clear", 32'hf0, rd)
    endtask
    task automatic t_ext();
        bus(1, `EIEC_OFS_PORT_EXT, 32'h3);
        bus(1, `EIEC_OFS_EXT_EDGE, 32'h1);
        @(posedge sys_clk) {ext_int_pin_a, ext_int_pin_b} <= 2'h3;
        idle(8);
        bus(0, `EIEC_OFS_REQ_A, 0);
        `CHK("ext rising", 32'h1, rd)
        @(posedge sys_clk) {ext_int_pin_a, ext_int_pin_b} <= 2'h0;
        idle(8);
        bus(0, `EIEC_OFS_REQ_A, 0);
        `CHK("ext falling", 32'h3, rd)
        bus(1, `EIEC_OFS_EVT_EDGE, 32'h1);
        @(posedge sys_clk) event_counter_int_pin <= 1'h1;
        idle(8);
        bus(0, `EIEC_OFS_REQ_A, 0);
        `CHK("event disabled", 32'h3, rd)
        bus(1, `EIEC_OFS_ENABLE_A, 32'h4);
        @(posedge sys_clk) event_counter_int_pin <= 1'h0;
        idle(6);
        event_counter_int_pin <= 1'h1;
        idle(8);
        bus(0, `EIEC_OFS_REQ_A, 0);
        `CHK("event enabled", 32'h7, rd)
        bus(1, `EIEC_OFS_REQ_A, 32'h2);
        bus(0, `EIEC_OFS_REQ_A, 0);
        `CHK("flag clear", 32'h2, rd)
    endtask
    task automatic t_irq();
        bus(1, `EIEC_OFS_ENABLE_A, 32'ha);
        idle(8);
        `CHK("before first insn", 1'h0, irq_req)
        run <= 1'h1;
        idle(40);
        `CHK("masked pending", 1'h0, exc_busy)
        cpu.set_ccr(8'h00);
        take_exc();
        `CHK("ext b vector", 16'h4500, pcv)
        `CHK("mask after stack", 8'h80, condition_code_reg)
        `CHK("pushed ccr", 16'h0000, cpu.ram[8'h7e])
        bus(0, `EIEC_OFS_REQ_A, 0);
        `CHK("flag kept", 32'h2, rd)
        bus(1, `EIEC_OFS_REQ_A, 32'h0);
        cpu.set_ccr(8'h00);
        take_exc();
        `CHK("wakeup vector", 16'h4700, pcv)
        bus(1, `EIEC_OFS_WAKE_REQ, 32'h0);
    endtask
    task automatic t_periph();
        bus(1, `EIEC_OFS_PERIPH_EN, 32'h0);
        @(posedge sys_clk) periph_evt <= 4'h1;
        @(posedge sys_clk) periph_evt <= 4'h0;
        bus(0, `EIEC_OFS_PERIPH_REQ, 0);
        `CHK("periph flag", 32'h1, rd)
        cpu.set_ccr(8'h00);
        idle(30);
        `CHK("periph masked", 1'h0, exc_busy)
        bus(1, `EIEC_OFS_PERIPH_EN, 32'h1);
        take_exc();
        `CHK("periph vector", 16'h4800, pcv)
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // reset held 10 cycles with the clock already stable, then the scenarios
    initial begin
        idle(10);
        rst_b <= 1'h1;
        t_reset();
        t_wake();
        t_ext();
        t_irq();
        t_periph();
        report_and_stop();
    end
    // watchdog well beyond the few hundred cycles the run needs
    initial begin
        idle(20000);
        n_errors++;
        report_and_stop();
    end
endmodule // tb
bind eiec_ctrl eiec_ctrl_props u_props (.sys_clk, .rst_b, .avs_read, .avs_write,
    .avs_waitrequest, .cpu_insn_end, .cpu_pc, .cpu_sp, .condition_code_reg, .irq_req,
    .irq_vec, .exc_busy, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .pc_load, .pc_value,
    .sp_load, .sp_value);
`default_nettype wire
